/* File: pkg/pmbus_cfg_pkg.sv */
// Constants, types and reset values for the command interpreter.
// Assumes one system clock; the bus front end hands over decoded transactions.
package pmbus_cfg_pkg;

  localparam logic [7:0] CMD_RUN_CONTROL    = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_SETUP   = 8'h02;
  localparam logic [7:0] CMD_WRITE_LOCK     = 8'h10;
  localparam logic [7:0] CMD_SAVE_CONFIG    = 8'h15;
  localparam logic [7:0] CMD_RELOAD_CONFIG  = 8'h16;
  localparam logic [7:0] CMD_FEATURE_REPORT = 8'h19;
  localparam logic [7:0] CMD_ALERT_MASK     = 8'h1B;
  localparam logic [7:0] STATUS_CODE_FIRST  = 8'h7A;
  localparam logic [7:0] STATUS_CODE_LAST   = 8'h7E;
  localparam int         STATUS_GROUPS      = 5;
  localparam int         CML_GROUP          = 4;
  localparam int         CML_IVC_BIT        = 7;
  localparam int         CML_IVD_BIT        = 6;

  localparam logic [7:0] LOCK_NONE     = 8'h00;
  localparam logic [7:0] LOCK_SETTINGS = 8'h20;
  localparam logic [7:0] LOCK_CONTROL  = 8'h40;
  localparam logic [7:0] LOCK_ALL      = 8'h80;
  localparam logic [7:0] PHASE_ALL     = 8'hFF;

  // Feature report fields, most significant first
  localparam logic       FR_PEC    = 1'b1;
  localparam logic [1:0] FR_SPEED  = 2'b10;
  localparam logic       FR_ALERT  = 1'b1;
  localparam logic       FR_FORMAT = 1'b0;
  localparam logic       FR_AVS    = 1'b0;
  localparam logic [1:0] FR_RSVD   = 2'b00;
  localparam logic [7:0] FEATURE_REPORT_VALUE =
    {FR_PEC, FR_SPEED, FR_ALERT, FR_FORMAT, FR_AVS, FR_RSVD};

  // Writable mask bits per status group, 7Ah first
  localparam logic [7:0] MASK_SUPPORTED [STATUS_GROUPS] =
    '{8'hFC, 8'hB0, 8'h08, 8'hC0, 8'hF2};

  // Working settings that have a user-store location
  localparam int NVM_ITEMS       = 9;
  localparam int NVM_WIDTH       = 16;
  localparam int ITEM_WRITE_LOCK = 0;
  localparam int ITEM_ON_OFF     = 1;
  localparam int ITEM_SETPOINT   = 2;
  localparam int ITEM_STRAP_SEL  = 3;
  localparam int ITEM_MASK_FIRST = 4;
  localparam int NVM_ITEM_CYCLES = 4;

  localparam int STRAP_SEL_SETPOINT_BIT = 0;
  localparam int STRAP_SEL_ON_OFF_BIT   = 1;

  localparam logic [15:0] WRITE_LOCK_RST  = 16'h0000;
  localparam logic [15:0] ON_OFF_RST      = 16'h0000;
  localparam logic [15:0] SETPOINT_RST    = 16'h0000;
  localparam logic [15:0] STRAP_SEL_RST   = 16'h0000;
  localparam logic [15:0] MASK_RST        = 16'h0000;
  localparam logic [7:0]  RUN_CONTROL_RST = 8'h00;

  typedef enum logic [2:0] {
    PROTO_SEND_BYTE,
    PROTO_WRITE_BYTE,
    PROTO_WRITE_WORD,
    PROTO_READ_BYTE,
    PROTO_READ_WORD,
    PROTO_BLOCK_CALL
  } proto_t;

  typedef enum logic [1:0] {
    NVM_IDLE,
    NVM_SAVING,
    NVM_LOADING
  } nvm_state_t;

endpackage : pmbus_cfg_pkg

/* File: pkg/nvm_if.sv */
// Link between the interpreter and the user-store sequencer.
// Both ends run on mclk; requests are one-cycle pulses.
`timescale 1ns/1ns
interface nvm_if #(
  parameter int ITEMS = 9,
  parameter int WIDTH = 16
);
  localparam int IW = $clog2(ITEMS);

  logic             save_req;
  logic             reload_req;
  logic             done;
  logic             ld_valid;
  logic [IW-1:0]    item_idx;
  logic [WIDTH-1:0] image_word;
  logic [WIDTH-1:0] ld_data;

  modport ctrl (
    output save_req,
    output reload_req,
    output image_word,
    input  done,
    input  ld_valid,
    input  item_idx,
    input  ld_data
  );

  modport store (
    input  save_req,
    input  reload_req,
    input  image_word,
    output done,
    output ld_valid,
    output item_idx,
    output ld_data
  );
endinterface : nvm_if

/* File: rtl/alert_gate.sv */
// One status group: sticky status bits and their alert suppression.
// Assumes condition inputs are synchronous to mclk.
`timescale 1ns/1ns
module alert_gate
  import pmbus_cfg_pkg::*;
#(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] SUPPORTED = 8'hFF
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Conditions and control
  input  wire logic [WIDTH-1:0] cond,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] mask,
  // Results
  output logic      [WIDTH-1:0] status,
  output logic                  alert
);

  logic [WIDTH-1:0] next_status;

  always_comb
  begin
    // New condition beats a clear in the same cycle
    next_status = (status & ~{WIDTH{clear}}) | cond;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      status <= '0;
    else
      status <= next_status;
  end

  assign alert = |(status & ~mask & SUPPORTED);

endmodule : alert_gate

/* File: rtl/nvm_store.sv */
// User store and the sequencer that copies it to or from working settings.
// Assumes the controller ignores new requests until done.
`timescale 1ns/1ns
module nvm_store
  import pmbus_cfg_pkg::*;
#(
  parameter int ITEMS       = NVM_ITEMS,
  parameter int WIDTH       = NVM_WIDTH,
  parameter int ITEM_CYCLES = NVM_ITEM_CYCLES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Controller side
  nvm_if.store      bus
);

  localparam int IW = $clog2(ITEMS);
  localparam int CW = $clog2(ITEM_CYCLES + 1);
  localparam logic [IW-1:0] LAST_IDX  = IW'(ITEMS - 1);
  localparam logic [CW-1:0] LAST_WAIT = CW'(ITEM_CYCLES - 1);

  nvm_state_t       state;
  nvm_state_t       next_state;
  logic [IW-1:0]    idx;
  logic [IW-1:0]    next_idx;
  logic [CW-1:0]    wait_cnt;
  logic [CW-1:0]    next_wait_cnt;
  logic [WIDTH-1:0] mem      [ITEMS];
  logic [WIDTH-1:0] next_mem [ITEMS];
  logic             step;

  assign step         = (state != NVM_IDLE) && (wait_cnt == LAST_WAIT);
  assign bus.item_idx = idx;
  assign bus.ld_data  = mem[idx];
  assign bus.ld_valid = step && (state == NVM_LOADING);
  assign bus.done     = step && (idx == LAST_IDX);

  always_comb
  begin
    next_state    = state;
    next_idx      = idx;
    next_wait_cnt = wait_cnt;
    next_mem      = mem;
    unique case (state)
      NVM_IDLE:
      begin
        next_idx      = '0;
        next_wait_cnt = '0;
        if (bus.save_req)
          next_state = NVM_SAVING;
        else if (bus.reload_req)
          next_state = NVM_LOADING;
      end
      NVM_SAVING, NVM_LOADING:
      begin
        next_wait_cnt = wait_cnt + CW'(1);
        if (step)
        begin
          next_wait_cnt = '0;
          if (state == NVM_SAVING)
            next_mem[idx] = bus.image_word;
          if (idx == LAST_IDX)
            next_state = NVM_IDLE;
          else
            next_idx = idx + IW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state    <= NVM_IDLE;
      idx      <= '0;
      wait_cnt <= '0;
      for (int i = 0; i < ITEMS; i++)
        mem[i] <= '0;
    end
    else
    begin
      state    <= next_state;
      idx      <= next_idx;
      wait_cnt <= next_wait_cnt;
      mem      <= next_mem;
    end
  end

endmodule : nvm_store

/* File: rtl/pmbus_protect_nvm_alert_mask.sv */
// Command interpreter: write lock, user-store save and reload,
// feature report and alert suppression masks.
// Assumes a bus front end on mclk that delivers one decoded transaction per pulse.
`timescale 1ns/1ns
module pmbus_protect_nvm_alert_mask
  import pmbus_cfg_pkg::*;
#(
  parameter logic [7:0] CMD_SETPOINT     = 8'h21,
  parameter logic [7:0] CMD_STRAP_SELECT = 8'hEE
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // Decoded transaction from the bus front end
  input  wire logic                          cmd_valid,
  input  wire logic [7:0]                    cmd_code,
  input  wire proto_t                        cmd_proto,
  input  wire logic [7:0]                    cmd_lo,
  input  wire logic [7:0]                    cmd_hi,
  // Answer to the bus front end
  output logic                               rsp_valid,
  output logic [15:0]                        rsp_data,
  output logic [1:0]                         rsp_len,
  output logic                               bus_hold,
  // Phase selector and sensed strap values
  input  wire logic [7:0]                    phase_sel,
  input  wire logic [15:0]                   strap_setpoint,
  input  wire logic [7:0]                    strap_on_off,
  // Status conditions and fault clearing
  input  wire logic [STATUS_GROUPS-1:0][7:0] status_cond,
  input  wire logic                          clear_faults,
  // Working settings to the regulator
  output logic [7:0]                         run_control,
  output logic [7:0]                         on_off_setup,
  output logic [15:0]                        output_setpoint,
  output logic                               reg_inhibit,
  // Open-drain alert pin
  output logic                               alert_o,
  output logic                               alert_oe
);

  nvm_if #(.ITEMS(NVM_ITEMS), .WIDTH(NVM_WIDTH)) nvm ();

  logic [15:0]                  work      [NVM_ITEMS];
  logic [15:0]                  next_work [NVM_ITEMS];
  logic [7:0]                   next_run_control;
  logic                         next_rsp_valid;
  logic [15:0]                  next_rsp_data;
  logic [1:0]                   next_rsp_len;
  logic                         save_req;
  logic                         next_save_req;
  logic                         reload_req;
  logic                         next_reload_req;
  logic                         nvm_active;
  logic                         next_nvm_active;
  logic                         reloading;
  logic                         next_reloading;
  logic                         next_reg_inhibit;
  logic                         ivd_hit;
  logic                         ivc_hit;
  logic                         is_write;
  logic                         permit;
  logic                         sel_ok;
  logic                         phase_all;
  logic [2:0]                   grp;
  logic [2:0]                   stat_grp;
  logic [STATUS_GROUPS-1:0]     grp_alert;
  logic [7:0]                   grp_status [STATUS_GROUPS];
  logic [STATUS_GROUPS-1:0][7:0] gate_cond;

  function automatic logic lock_permits(input logic [7:0] level, input logic [7:0] code);
    logic ok;
    ok = 1'b0;
    case (level)
      LOCK_NONE:     ok = 1'b1;
      LOCK_SETTINGS: ok = (code == CMD_WRITE_LOCK) || (code == CMD_RUN_CONTROL) ||
                          (code == CMD_ON_OFF_SETUP) || (code == CMD_SAVE_CONFIG) ||
                          (code == CMD_SETPOINT);
      LOCK_CONTROL:  ok = (code == CMD_WRITE_LOCK) || (code == CMD_RUN_CONTROL) ||
                          (code == CMD_SAVE_CONFIG);
      LOCK_ALL:      ok = (code == CMD_WRITE_LOCK) || (code == CMD_SAVE_CONFIG);
      default:       ok = 1'b0;
    endcase
    return ok;
  endfunction : lock_permits

  assign is_write  = (cmd_proto == PROTO_SEND_BYTE) || (cmd_proto == PROTO_WRITE_BYTE) ||
                     (cmd_proto == PROTO_WRITE_WORD);
  assign permit    = lock_permits(work[ITEM_WRITE_LOCK][7:0], cmd_code);
  assign phase_all = (phase_sel == PHASE_ALL);
  assign sel_ok    = (cmd_lo >= STATUS_CODE_FIRST) && (cmd_lo <= STATUS_CODE_LAST);
  assign grp       = 3'(cmd_lo - STATUS_CODE_FIRST);
  assign stat_grp  = 3'(cmd_code - STATUS_CODE_FIRST);

  assign nvm.save_req   = save_req;
  assign nvm.reload_req = reload_req;
  // Settings without a store location never reach this mux
  assign nvm.image_word = work[nvm.item_idx];

  always_comb
  begin
    next_work        = work;
    next_run_control = run_control;
    next_rsp_valid   = 1'b0;
    next_rsp_data    = rsp_data;
    next_rsp_len     = rsp_len;
    next_save_req    = 1'b0;
    next_reload_req  = 1'b0;
    next_nvm_active  = nvm_active;
    next_reloading   = reloading;
    next_reg_inhibit = reg_inhibit;
    ivd_hit          = 1'b0;
    ivc_hit          = 1'b0;
    // Transactions during a store copy are dropped
    if (cmd_valid && !nvm_active)
    begin
      if (is_write && !permit && (cmd_code != CMD_FEATURE_REPORT))
        ivd_hit = 1'b1;
      else
      begin
        case (cmd_code)
          CMD_RUN_CONTROL:
          begin
            if (cmd_proto == PROTO_WRITE_BYTE)
              next_run_control = cmd_lo;
            else if (cmd_proto == PROTO_READ_BYTE)
            begin
              next_rsp_valid = 1'b1;
              next_rsp_data  = {8'h00, run_control};
              next_rsp_len   = 2'd1;
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_ON_OFF_SETUP:
          begin
            if (cmd_proto == PROTO_WRITE_BYTE)
              next_work[ITEM_ON_OFF] = {8'h00, cmd_lo};
            else if (cmd_proto == PROTO_READ_BYTE)
            begin
              next_rsp_valid = 1'b1;
              next_rsp_data  = work[ITEM_ON_OFF];
              next_rsp_len   = 2'd1;
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_WRITE_LOCK:
          begin
            if (cmd_proto == PROTO_WRITE_BYTE)
            begin
              if ((cmd_lo == LOCK_NONE) || (cmd_lo == LOCK_SETTINGS) ||
                  (cmd_lo == LOCK_CONTROL) || (cmd_lo == LOCK_ALL))
                next_work[ITEM_WRITE_LOCK] = {8'h00, cmd_lo};
              else
                ivd_hit = 1'b1;
            end
            else if (cmd_proto == PROTO_READ_BYTE)
            begin
              next_rsp_valid = 1'b1;
              next_rsp_data  = work[ITEM_WRITE_LOCK];
              next_rsp_len   = 2'd1;
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_SAVE_CONFIG:
          begin
            if (cmd_proto == PROTO_SEND_BYTE)
            begin
              next_save_req   = 1'b1;
              next_nvm_active = 1'b1;
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_RELOAD_CONFIG:
          begin
            if (cmd_proto == PROTO_SEND_BYTE)
            begin
              next_reload_req  = 1'b1;
              next_nvm_active  = 1'b1;
              next_reloading   = 1'b1;
              next_reg_inhibit = 1'b1;
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_FEATURE_REPORT:
          begin
            if (is_write)
              ivd_hit = 1'b1;
            else if (cmd_proto == PROTO_READ_BYTE)
            begin
              next_rsp_valid = 1'b1;
              next_rsp_data  = {8'h00, FEATURE_REPORT_VALUE};
              next_rsp_len   = 2'd1;
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_ALERT_MASK:
          begin
            // Masks exist only for the all-phases view
            if ((cmd_proto == PROTO_WRITE_WORD) || (cmd_proto == PROTO_BLOCK_CALL))
            begin
              if (!sel_ok || !phase_all)
                ivd_hit = 1'b1;
              else if (cmd_proto == PROTO_WRITE_WORD)
                next_work[ITEM_MASK_FIRST + int'(grp)] =
                  {8'h00, cmd_hi & MASK_SUPPORTED[grp]};
              else
              begin
                next_rsp_valid = 1'b1;
                next_rsp_data  = work[ITEM_MASK_FIRST + int'(grp)];
                next_rsp_len   = 2'd1;
              end
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_SETPOINT:
          begin
            if (cmd_proto == PROTO_WRITE_WORD)
              next_work[ITEM_SETPOINT] = {cmd_hi, cmd_lo};
            else if (cmd_proto == PROTO_READ_WORD)
            begin
              next_rsp_valid = 1'b1;
              next_rsp_data  = work[ITEM_SETPOINT];
              next_rsp_len   = 2'd2;
            end
            else
              ivc_hit = 1'b1;
          end
          CMD_STRAP_SELECT:
          begin
            if (cmd_proto == PROTO_WRITE_BYTE)
              next_work[ITEM_STRAP_SEL] = {8'h00, cmd_lo};
            else if (cmd_proto == PROTO_READ_BYTE)
            begin
              next_rsp_valid = 1'b1;
              next_rsp_data  = work[ITEM_STRAP_SEL];
              next_rsp_len   = 2'd1;
            end
            else
              ivc_hit = 1'b1;
          end
          default:
          begin
            // Status bytes read back, still set even when masked
            if ((cmd_code >= STATUS_CODE_FIRST) && (cmd_code <= STATUS_CODE_LAST) &&
                (cmd_proto == PROTO_READ_BYTE))
            begin
              next_rsp_valid = 1'b1;
              next_rsp_data  = {8'h00, grp_status[stat_grp]};
              next_rsp_len   = 2'd1;
            end
            else
              ivc_hit = 1'b1;
          end
        endcase
      end
    end
    if (nvm.ld_valid)
      next_work[nvm.item_idx] = nvm.ld_data;
    if (nvm.done)
    begin
      next_nvm_active  = 1'b0;
      next_reloading   = 1'b0;
      next_reg_inhibit = 1'b0;
      // Strap values win over what the store held
      if (reloading && work[ITEM_STRAP_SEL][STRAP_SEL_SETPOINT_BIT])
        next_work[ITEM_SETPOINT] = strap_setpoint;
      if (reloading && work[ITEM_STRAP_SEL][STRAP_SEL_ON_OFF_BIT])
        next_work[ITEM_ON_OFF] = {8'h00, strap_on_off};
    end
  end

  always_comb
  begin
    gate_cond = status_cond;
    gate_cond[CML_GROUP][CML_IVC_BIT] = status_cond[CML_GROUP][CML_IVC_BIT] | ivc_hit;
    gate_cond[CML_GROUP][CML_IVD_BIT] = status_cond[CML_GROUP][CML_IVD_BIT] | ivd_hit;
  end

  for (genvar g = 0; g < STATUS_GROUPS; g++)
  begin : g_group
    alert_gate #(
      .WIDTH     (8),
      .SUPPORTED (MASK_SUPPORTED[g])
    ) u_gate (
      .mclk   (mclk),
      .rst    (rst),
      .cond   (gate_cond[g]),
      .clear  (clear_faults),
      .mask   (work[ITEM_MASK_FIRST + g][7:0]),
      .status (grp_status[g]),
      .alert  (grp_alert[g])
    );
  end

  nvm_store #(
    .ITEMS       (NVM_ITEMS),
    .WIDTH       (NVM_WIDTH),
    .ITEM_CYCLES (NVM_ITEM_CYCLES)
  ) u_store (
    .mclk (mclk),
    .rst  (rst),
    .bus  (nvm.store)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      work[ITEM_WRITE_LOCK] <= WRITE_LOCK_RST;
      work[ITEM_ON_OFF]     <= ON_OFF_RST;
      work[ITEM_SETPOINT]   <= SETPOINT_RST;
      work[ITEM_STRAP_SEL]  <= STRAP_SEL_RST;
      for (int i = ITEM_MASK_FIRST; i < NVM_ITEMS; i++)
        work[i] <= MASK_RST;
      run_control <= RUN_CONTROL_RST;
      rsp_valid   <= 1'b0;
      rsp_data    <= 16'h0000;
      rsp_len     <= 2'd0;
      save_req    <= 1'b0;
      reload_req  <= 1'b0;
      nvm_active  <= 1'b0;
      reloading   <= 1'b0;
      reg_inhibit <= 1'b0;
    end
    else
    begin
      work        <= next_work;
      run_control <= next_run_control;
      rsp_valid   <= next_rsp_valid;
      rsp_data    <= next_rsp_data;
      rsp_len     <= next_rsp_len;
      save_req    <= next_save_req;
      reload_req  <= next_reload_req;
      nvm_active  <= next_nvm_active;
      reloading   <= next_reloading;
      reg_inhibit <= next_reg_inhibit;
    end
  end

  // Registered copies so every output leaves from a flop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      on_off_setup    <= ON_OFF_RST[7:0];
      output_setpoint <= SETPOINT_RST;
      bus_hold        <= 1'b0;
      alert_o         <= 1'b0;
      alert_oe        <= 1'b0;
    end
    else
    begin
      on_off_setup    <= next_work[ITEM_ON_OFF][7:0];
      output_setpoint <= next_work[ITEM_SETPOINT];
      bus_hold        <= next_nvm_active;
      alert_o         <= 1'b0;
      alert_oe        <= |grp_alert;
    end
  end

endmodule : pmbus_protect_nvm_alert_mask

/* File: verification/pmbus_chk.sv */
// Checker of the interpreter's port relations.
// Assumes binding to the top; one clock, synchronous reset.
`timescale 1ns/1ns
module pmbus_chk
  import pmbus_cfg_pkg::*;
(
  // Clock, reset, command
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire proto_t      cmd_proto,
  // Outputs watched
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [1:0]  rsp_len,
  input wire logic        bus_hold,
  input wire logic        reg_inhibit,
  input wire logic [15:0] output_setpoint,
  input wire logic        alert_o,
  input wire logic        alert_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic go = cmd_valid && !bus_hold;
  property p_feat; go && cmd_code == CMD_FEATURE_REPORT && cmd_proto == PROTO_READ_BYTE
    |=> rsp_valid && rsp_data == 16'h00D0 && rsp_len == 2'h1; endproperty
  a_feat: assert property (p_feat) else $error("feature read");
  property p_lock; go && cmd_code == CMD_WRITE_LOCK && cmd_proto == PROTO_READ_BYTE
    |=> rsp_valid && rsp_len == 2'h1; endproperty
  a_lock: assert property (p_lock) else $error("lock read");
  property p_save; go && cmd_code == CMD_SAVE_CONFIG |=> bus_hold; endproperty
  a_save: assert property (p_save) else $error("save start");
  property p_span; $rose(bus_hold) |-> ##[30:45] !bus_hold; endproperty
  a_span: assert property (p_span) else $error("copy length");
  property p_load; go && cmd_code == CMD_RELOAD_CONFIG |=> reg_inhibit; endproperty
  a_load: assert property (p_load) else $error("reload start");
  property p_inh; reg_inhibit |-> bus_hold; endproperty
  a_inh: assert property (p_inh) else $error("inhibit span");
  property p_pin; alert_oe |-> !alert_o; endproperty
  a_pin: assert property (p_pin) else $error("alert level");
  property p_keep; $changed(output_setpoint) |-> $past(cmd_valid) || $past(cmd_valid, 2)
    || $past(bus_hold) || $past(bus_hold, 2); endproperty
  a_keep: assert property (p_keep) else $error("setpoint moved");
endmodule : pmbus_chk
bind pmbus_protect_nvm_alert_mask pmbus_chk u_chk (.mclk, .rst, .cmd_valid, .cmd_code,
  .cmd_proto, .rsp_valid, .rsp_data, .rsp_len, .bus_hold, .reg_inhibit, .output_setpoint,
  .alert_o, .alert_oe);

/* File: verification/pmbus_host.sv */
// Host model: one decoded transaction at a time.
// Assumes the caller waits out store copies first.
`timescale 1ns/1ns
module pmbus_host
  import pmbus_cfg_pkg::*;
(
  // Clock
  input  wire logic  mclk,
  // Transaction
  output logic       cmd_valid = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output proto_t     cmd_proto = PROTO_SEND_BYTE,
  output logic [7:0] cmd_lo = 8'h00,
  output logic [7:0] cmd_hi = 8'h00
);
  task automatic send(input logic [7:0] c, input proto_t p, input logic [15:0] d);
    @(posedge mclk);
    #5;
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_proto = p;
    {cmd_hi, cmd_lo} = d;
    @(posedge mclk);
    #5;
    cmd_valid = 1'b0;
    // Idle data never echoes the last byte
    {cmd_hi, cmd_lo} = ~d;
  endtask : send
endmodule : pmbus_host

/* File: verification/test_pmbus_protect_nvm_alert_mask.sv */
// Bench for the interpreter with host model and bound checker.
// Assumes 10 MHz mclk and the package store timing.
`timescale 1ns/1ns
module test_pmbus_protect_nvm_alert_mask
  import pmbus_cfg_pkg::*;
  ;
  logic mclk = 1'b0, rst = 1'b1, clear_faults = 1'b0, cmd_valid, rsp_valid;
  logic bus_hold, reg_inhibit, alert_o, alert_oe;
  logic [7:0] cmd_code, cmd_lo, cmd_hi, run_control, on_off_setup;
  logic [7:0] lvl[4] = '{LOCK_NONE, LOCK_SETTINGS, LOCK_CONTROL, LOCK_ALL};
  logic [7:0] phase_sel = 8'hFF, strap_on_off = 8'h00;
  logic [15:0] rsp_data, output_setpoint, strap_setpoint = 16'h0000, v, sp = 16'h0000;
  logic [15:0] rc = 16'h0000, expq[$];
  logic [1:0] rsp_len;
  logic [STATUS_GROUPS-1:0][7:0] status_cond = '0;
  proto_t cmd_proto;
  int fail_count = 0, samples_checked = 0;
  always #50 mclk = ~mclk;
  pmbus_protect_nvm_alert_mask u_dut (.mclk, .rst, .cmd_valid, .cmd_code, .cmd_proto,
    .cmd_lo, .cmd_hi, .rsp_valid, .rsp_data, .rsp_len, .bus_hold, .phase_sel,
    .strap_setpoint, .strap_on_off, .status_cond, .clear_faults, .run_control,
    .on_off_setup, .output_setpoint, .reg_inhibit, .alert_o, .alert_oe);
  pmbus_host u_host (.mclk, .cmd_valid, .cmd_code, .cmd_proto, .cmd_lo, .cmd_hi);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d bad %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic rd(input logic [7:0] c, input proto_t p, input logic [7:0] lo,
                    input logic [15:0] e);
    expq.push_back(e);
    u_host.send(c, p, {8'h00, lo});
  endtask : rd
  task automatic idle;
    for (int n = 0; n < 100 && bus_hold !== 1'b0; n++)
      @(negedge mclk);
    if (bus_hold !== 1'b0)
    begin
      fail_count++;
      results();
    end
    repeat (3) @(negedge mclk);
  endtask : idle
  task automatic clr;
    @(posedge mclk);
    #5 clear_faults = 1'b1;
    @(posedge mclk);
    #5 clear_faults = 1'b0;
  endtask : clr
  // Answers are matched in order; a stray answer meets an unknown and fails
  always @(negedge mclk)
    if (rsp_valid === 1'b1)
      chk(rsp_data, expq.size() > 0 ? expq.pop_front() : 16'hXXXX);
  initial
  begin
    void'($urandom(84922));
    repeat (5) @(posedge mclk);
    #5 rst = 1'b0;
    idle();
    chk({alert_oe, run_control, 7'h00}, 16'h0000);
    rd(CMD_FEATURE_REPORT, PROTO_READ_BYTE, 8'h00, 16'h00D0);
    u_host.send(CMD_FEATURE_REPORT, PROTO_WRITE_BYTE, 16'h00FF);
    rd(8'h7E, PROTO_READ_BYTE, 8'h00, 16'h0040);
    clr();
    u_host.send(CMD_WRITE_LOCK, PROTO_WRITE_BYTE, 16'h0033);
    rd(CMD_WRITE_LOCK, PROTO_READ_BYTE, 8'h00, 16'h0000);
    clr();
    $display("report done");
    foreach (lvl[i])
    begin
      v = 16'($urandom);
      u_host.send(CMD_WRITE_LOCK, PROTO_WRITE_BYTE, {8'h00, lvl[i]});
      u_host.send(u_dut.CMD_SETPOINT, PROTO_WRITE_WORD, v);
      u_host.send(CMD_RUN_CONTROL, PROTO_WRITE_BYTE, 16'(i + 1));
      if (lvl[i] <= LOCK_SETTINGS) sp = v;
      if (lvl[i] != LOCK_ALL) rc = 16'(i + 1);
      idle();
      chk(output_setpoint, sp);
      chk({8'h00, run_control}, rc);
      rd(CMD_WRITE_LOCK, PROTO_READ_BYTE, 8'h00, {8'h00, lvl[i]});
    end
    u_host.send(CMD_WRITE_LOCK, PROTO_WRITE_BYTE, 16'h0000);
    $display("lock done");
    u_host.send(CMD_ALERT_MASK, PROTO_WRITE_WORD, 16'hFF7A);
    rd(CMD_ALERT_MASK, PROTO_BLOCK_CALL, 8'h7A, 16'h00FC);
    phase_sel = 8'h00;
    u_host.send(CMD_ALERT_MASK, PROTO_WRITE_WORD, 16'h007A);
    phase_sel = 8'hFF;
    rd(CMD_ALERT_MASK, PROTO_BLOCK_CALL, 8'h7A, 16'h00FC);
    // Refused writes above left the invalid-data flag raising the alert
    clr();
    status_cond[0] = 8'h84;
    idle();
    chk({15'h0000, alert_oe}, 16'h0000);
    rd(8'h7A, PROTO_READ_BYTE, 8'h00, 16'h0084);
    u_host.send(CMD_ALERT_MASK, PROTO_WRITE_WORD, 16'h007A);
    idle();
    chk({15'h0000, alert_oe}, 16'h0001);
    status_cond[0] = 8'h00;
    clr();
    $display("mask done");
    for (int j = 0; j < 2; j++)
    begin
      v = 16'($urandom);
      strap_setpoint = ~v;
      strap_on_off = v[15:8];
      u_host.send(u_dut.CMD_STRAP_SELECT, PROTO_WRITE_BYTE, 16'(3 * j));
      u_host.send(u_dut.CMD_SETPOINT, PROTO_WRITE_WORD, v);
      u_host.send(CMD_ON_OFF_SETUP, PROTO_WRITE_BYTE, v);
      u_host.send(CMD_SAVE_CONFIG, PROTO_SEND_BYTE, 16'h0000);
      idle();
      u_host.send(u_dut.CMD_SETPOINT, PROTO_WRITE_WORD, v ^ 16'h00FF);
      u_host.send(CMD_ON_OFF_SETUP, PROTO_WRITE_BYTE, ~v);
      u_host.send(CMD_RELOAD_CONFIG, PROTO_SEND_BYTE, 16'h0000);
      idle();
      chk(output_setpoint, j ? ~v : v);
      chk({8'h00, on_off_setup}, {8'h00, j ? v[15:8] : v[7:0]});
    end
    $display("store done");
    chk(16'(expq.size()), 16'h0000);
    results();
  end
endmodule : test_pmbus_protect_nvm_alert_mask
